/* File: include/ccd_seq_pkg.sv */
// Constants and types shared by the sensor readout sequencer
package ccd_seq_pkg;

  // ****************************************
  // Clock and pulse timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_VPW0_NS     = 1500;
  localparam int unsigned T_VPW1_NS     = 3000;
  localparam int unsigned T_VPW2_NS     = 6000;
  localparam int unsigned T_VPW3_NS     = 12000;
  localparam int unsigned T_HPW_NS      = 1000;
  localparam int unsigned T_RG_NS       = 100;
  localparam int unsigned T_OVR_NS      = 1000;

  // Least times round up to whole cycles
  localparam logic [31:0] VPW0_CYC = 32'((T_VPW0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] VPW1_CYC = 32'((T_VPW1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] VPW2_CYC = 32'((T_VPW2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] VPW3_CYC = 32'((T_VPW3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] HPW_CYC  = 32'((T_HPW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] RG_CYC   = 32'((T_RG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] OVR_CYC  = 32'((T_OVR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************
  // Array geometry
  // ****************************************
  localparam logic [9:0]  ROWS_SMALL = 10'h080;
  localparam logic [9:0]  ROWS_MID   = 10'h100;
  localparam logic [9:0]  ROWS_LARGE = 10'h200;
  localparam logic [11:0] COLS_NARROW = 12'h414;
  localparam logic [11:0] COLS_WIDE   = 12'h814;

  // ****************************************
  // Data path
  // ****************************************
  localparam int unsigned ADC_W      = 16;
  localparam int unsigned FIFO_W     = ADC_W + 1;
  localparam int unsigned FIFO_DEPTH = 32;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_INTEG = 7'h02,
    ST_VPH2  = 7'h04,
    ST_OVR   = 7'h08,
    ST_VPH1  = 7'h10,
    ST_HPH2  = 7'h20,
    ST_HPH1  = 7'h40
  } seq_state_e;

endpackage

/* File: core/pixel_fifo.sv */
// Synchronous FIFO with registered read data for the pixel stream
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             ov_q, ov_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic             push, pop;

  // One word may sit in the output register beyond the array
  always_comb begin
    in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    push       = in_valid_i && in_ready_o;
    pop        = (cnt_q != '0) && (!ov_q || out_ready_i);
    wr_d       = push ? wr_q + 1'b1 : wr_q;
    rd_d       = pop ? rd_q + 1'b1 : rd_q;
    cnt_d      = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    od_d       = pop ? mem_q[rd_q] : od_q;
    ov_d       = pop ? 1'b1 : (out_ready_i ? 1'b0 : ov_q);
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      ov_q  <= 1'b0;
      od_q  <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      ov_q  <= ov_d;
      od_q  <= od_d;
    end
  end

  assign out_valid_o = ov_q;
  assign out_data_o  = od_q;
endmodule
`default_nettype wire

/* File: core/ccd_readout_host.sv */
// Timing generator that clocks a full-frame area sensor and collects its pixels
`timescale 1ns/1ps
`default_nettype none
module ccd_readout_host import ccd_seq_pkg::*; (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              start_i,
  input  wire logic              area_mode_i,
  input  wire logic [1:0]        row_sel_i,
  input  wire logic              col_sel_i,
  input  wire logic [31:0]       integ_cycles_i,
  input  wire logic [ADC_W-1:0]  adc_data_i,
  input  wire logic              pix_ready_i,
  output logic                   vert_clock_phase1_o,
  output logic                   vert_clock_phase2_o,
  output logic                   transfer_gate_o,
  output logic                   horiz_clock_phase1_o,
  output logic                   horiz_clock_phase2_o,
  output logic                   summing_gate_o,
  output logic                   reset_gate_o,
  output logic                   shutter_open_o,
  output logic                   adc_sample_o,
  output logic                   busy_o,
  output logic                   frame_done_o,
  output logic                   pix_valid_o,
  output logic [ADC_W-1:0]       pix_data_o,
  output logic                   pix_line_end_o
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_m_q, rst_s_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // ****************************************
  // Converter input synchroniser
  // ****************************************
  logic [ADC_W-1:0] adc_m_q, adc_s_q;

  always_ff @(posedge clk_sys_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      adc_m_q <= '0;
      adc_s_q <= '0;
    end else begin
      adc_m_q <= adc_data_i;
      adc_s_q <= adc_m_q;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  seq_state_e  state_q, state_d;
  logic [31:0] tmr_q, tmr_d;
  logic [31:0] integ_q, integ_d;
  logic [31:0] vpw_q, vpw_d;
  logic [9:0]  rows_q, rows_d, row_q, row_d;
  logic [11:0] cols_q, cols_d, col_q, col_d;
  logic        area_q, area_d;
  logic        line_pend_q, line_pend_d;
  logic        p1v_q, p1v_d, p2v_q, p2v_d;
  logic        p1h_q, p1h_d, p2h_q, p2h_d;
  logic        rg_q, rg_d, shut_q, shut_d;
  logic        done_q, done_d, smp_q, smp_d;
  logic [31:0] lim;
  logic        tdone;
  logic        push;
  logic        fifo_in_ready;
  logic [FIFO_W-1:0] fifo_out;
  logic [1:0]  vidx;

  always_comb begin
    state_d     = state_q;
    tmr_d       = tmr_q;
    integ_d     = integ_q;
    vpw_d       = vpw_q;
    rows_d      = rows_q;
    cols_d      = cols_q;
    row_d       = row_q;
    col_d       = col_q;
    area_d      = area_q;
    line_pend_d = line_pend_q;
    done_d      = 1'b0;
    push        = 1'b0;
    vidx        = 2'h0;

    case (state_q)
      ST_INTEG:            lim = integ_q;
      ST_VPH1, ST_VPH2:    lim = vpw_q;
      ST_OVR:              lim = OVR_CYC;
      ST_HPH1, ST_HPH2:    lim = HPW_CYC;
      default:             lim = 32'h0000_0001;
    endcase
    tdone = (tmr_q + 32'h0000_0001 >= lim);

    case (state_q)
      ST_IDLE: begin
        tmr_d = '0;
        if (start_i) begin
          integ_d = integ_cycles_i;
          area_d  = area_mode_i;
          case (row_sel_i)
            2'h0:    rows_d = ROWS_SMALL;
            2'h1:    rows_d = ROWS_MID;
            default: rows_d = ROWS_LARGE;
          endcase
          cols_d = col_sel_i ? COLS_WIDE : COLS_NARROW;
          // Longer vertical registers load the phases harder
          vidx = ((row_sel_i == 2'h3) ? 2'h2 : row_sel_i) + {1'b0, col_sel_i};
          case (vidx)
            2'h0:    vpw_d = VPW0_CYC;
            2'h1:    vpw_d = VPW1_CYC;
            2'h2:    vpw_d = VPW2_CYC;
            default: vpw_d = VPW3_CYC;
          endcase
          row_d       = '0;
          col_d       = '0;
          line_pend_d = 1'b0;
          state_d     = ST_INTEG;
        end
      end
      ST_INTEG: begin
        tmr_d = tmr_q + 32'h0000_0001;
        if (tdone) begin
          tmr_d   = '0;
          state_d = ST_VPH2;
        end
      end
      ST_VPH2: begin
        tmr_d = tmr_q + 32'h0000_0001;
        if (tdone) begin
          tmr_d = '0;
          row_d = row_q + 10'h001;
          // Area scan reads after every row; binning only after the last
          if (area_q || (row_q + 10'h001 == rows_q)) begin
            state_d = ST_OVR;
          end else begin
            state_d = ST_VPH1;
          end
        end
      end
      ST_OVR: begin
        tmr_d = tmr_q + 32'h0000_0001;
        if (tdone) begin
          tmr_d       = '0;
          line_pend_d = 1'b1;
          state_d     = ST_VPH1;
        end
      end
      ST_VPH1: begin
        tmr_d = tmr_q + 32'h0000_0001;
        if (tdone) begin
          tmr_d   = '0;
          col_d   = '0;
          state_d = line_pend_q ? ST_HPH2 : ST_VPH2;
        end
      end
      ST_HPH2: begin
        tmr_d = tmr_q + 32'h0000_0001;
        if (tdone) begin
          // A full FIFO stretches this phase rather than drop a pixel
          if (fifo_in_ready) begin
            push    = 1'b1;
            tmr_d   = '0;
            state_d = ST_HPH1;
          end else begin
            tmr_d = tmr_q;
          end
        end
      end
      ST_HPH1: begin
        tmr_d = tmr_q + 32'h0000_0001;
        if (tdone) begin
          tmr_d = '0;
          col_d = col_q + 12'h001;
          if (col_q + 12'h001 == cols_q) begin
            line_pend_d = 1'b0;
            if (row_q == rows_q) begin
              done_d  = 1'b1;
              state_d = ST_IDLE;
            end else begin
              state_d = ST_VPH2;
            end
          end else begin
            state_d = ST_HPH2;
          end
        end
      end
      default: begin
        tmr_d   = '0;
        state_d = ST_IDLE;
      end
    endcase

    // Pin levels follow the next state so each toggles from one flip-flop
    p2v_d  = (state_d == ST_VPH2) || (state_d == ST_OVR);
    p1v_d  = !p2v_d;
    p2h_d  = (state_d == ST_HPH2);
    p1h_d  = !p2h_d;
    rg_d   = (state_d == ST_HPH1) && (tmr_d < RG_CYC);
    shut_d = (state_d == ST_INTEG);
    smp_d  = push;
  end

  always_ff @(posedge clk_sys_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      state_q     <= ST_IDLE;
      tmr_q       <= '0;
      integ_q     <= '0;
      vpw_q       <= VPW0_CYC;
      rows_q      <= ROWS_SMALL;
      cols_q      <= COLS_NARROW;
      row_q       <= '0;
      col_q       <= '0;
      area_q      <= 1'b0;
      line_pend_q <= 1'b0;
      p1v_q       <= 1'b1;
      p2v_q       <= 1'b0;
      p1h_q       <= 1'b1;
      p2h_q       <= 1'b0;
      rg_q        <= 1'b0;
      shut_q      <= 1'b0;
      done_q      <= 1'b0;
      smp_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      tmr_q       <= tmr_d;
      integ_q     <= integ_d;
      vpw_q       <= vpw_d;
      rows_q      <= rows_d;
      cols_q      <= cols_d;
      row_q       <= row_d;
      col_q       <= col_d;
      area_q      <= area_d;
      line_pend_q <= line_pend_d;
      p1v_q       <= p1v_d;
      p2v_q       <= p2v_d;
      p1h_q       <= p1h_d;
      p2h_q       <= p2h_d;
      rg_q        <= rg_d;
      shut_q      <= shut_d;
      done_q      <= done_d;
      smp_q       <= smp_d;
    end
  end

  // ****************************************
  // Pixel buffer
  // ****************************************
  pixel_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_sys_i),
    .rst_n_i     (rst_s_q),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({(col_q + 12'h001 == cols_q), adc_s_q}),
    .out_valid_o (pix_valid_o),
    .out_ready_i (pix_ready_i),
    .out_data_o  (fifo_out)
  );

  assign pix_data_o           = fifo_out[ADC_W-1:0];
  assign pix_line_end_o       = fifo_out[ADC_W];
  assign vert_clock_phase1_o  = p1v_q;
  assign vert_clock_phase2_o  = p2v_q;
  assign transfer_gate_o      = p2v_q;
  assign horiz_clock_phase1_o = p1h_q;
  assign horiz_clock_phase2_o = p2h_q;
  assign summing_gate_o       = p2h_q;
  assign reset_gate_o         = rg_q;
  assign shutter_open_o       = shut_q;
  assign adc_sample_o         = smp_q;
  assign busy_o               = (state_q != ST_IDLE);
  assign frame_done_o         = done_q;
endmodule
`default_nettype wire

/* File: sim/ccd_sensor_model.sv */
// Behavioural sensor: element n of a line reads back as value n
`timescale 1ns/1ps
`default_nettype none
module ccd_sensor_model import ccd_seq_pkg::*; (
  input  wire logic             transfer_gate_i,
  input  wire logic             summing_gate_i,
  input  wire logic             reset_gate_i,
  output logic      [ADC_W-1:0] pixel_output_o
);
  logic [ADC_W-1:0] elem_q = '0;

  // Each summing gate fall moves the next element onto the sense node
  always @(posedge transfer_gate_i or negedge summing_gate_i) begin
    if (transfer_gate_i) begin
      elem_q <= '0;
    end else begin
      elem_q <= elem_q + ADC_W'(1);
    end
  end

  // A cleared sense node shows no valid pixel, so drive a distinct value
  assign pixel_output_o = reset_gate_i ? ~elem_q : elem_q;
endmodule
`default_nettype wire

/* File: sim/ccd_readout_host_chk.sv */
// Pin-level assertions on the readout sequencer
`timescale 1ns/1ps
`default_nettype none
module ccd_readout_host_chk import ccd_seq_pkg::*; (
  input wire logic             clk_sys_i,
  input wire logic             rst_n_i,
  input wire logic             start_i,
  input wire logic             pix_ready_i,
  input wire logic             vert_clock_phase1_o,
  input wire logic             vert_clock_phase2_o,
  input wire logic             transfer_gate_o,
  input wire logic             horiz_clock_phase1_o,
  input wire logic             horiz_clock_phase2_o,
  input wire logic             summing_gate_o,
  input wire logic             reset_gate_o,
  input wire logic             shutter_open_o,
  input wire logic             busy_o,
  input wire logic             frame_done_o,
  input wire logic             pix_valid_o,
  input wire logic [ADC_W-1:0] pix_data_o,
  input wire logic             pix_line_end_o
);
  // ****************************************
  // Run-length counters, saturating
  // ****************************************
  logic [15:0] hrun_q;
  logic [15:0] vrun_q;
  logic [15:0] tgrun_q;
  logic [15:0] tglast_q;
  logic        vmoved_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrun_q <= '0;
      vrun_q <= '0;
      tgrun_q  <= '0;
      tglast_q <= '0;
      vmoved_q <= 1'b0;
    end else begin
      hrun_q <= $changed(horiz_clock_phase1_o) ? 16'h0001 : hrun_q + 16'(hrun_q != 16'hffff);
      vrun_q <= $changed(vert_clock_phase1_o) ? 16'h0001 : vrun_q + 16'(vrun_q != 16'hffff);
      tgrun_q  <= transfer_gate_o ? tgrun_q + 16'(tgrun_q != 16'hffff) : '0;
      tglast_q <= $fell(transfer_gate_o) ? tgrun_q : tglast_q;
      // Flag a vertical move whose line readout has not yet begun
      vmoved_q <= $fell(transfer_gate_o) ? 1'b1 :
                  ($rose(horiz_clock_phase2_o) ? 1'b0 : vmoved_q);
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // ****************************************
  // Assertions
  // ****************************************
  AST_VERT_COMP: assert property (vert_clock_phase2_o == !vert_clock_phase1_o)
    else $error("vertical phases not complementary");
  AST_HORIZ_COMP: assert property (horiz_clock_phase2_o == !horiz_clock_phase1_o)
    else $error("horizontal phases not complementary");
  AST_TG_FOLLOW: assert property (transfer_gate_o == vert_clock_phase2_o)
    else $error("transfer gate differs from vertical phase 2");
  AST_SG_FOLLOW: assert property (summing_gate_o == horiz_clock_phase2_o)
    else $error("summing gate differs from horizontal phase 2");
  AST_RG_WIDTH: assert property ($rose(reset_gate_o) |-> reset_gate_o [*5])
    else $error("reset gate pulse too short");
  AST_RG_PHASE: assert property (reset_gate_o |-> horiz_clock_phase1_o && !summing_gate_o)
    else $error("reset gate outside phase 1 half");
  AST_HPW: assert property ($changed(horiz_clock_phase1_o) |-> hrun_q >= 16'(HPW_CYC))
    else $error("horizontal half period too short");
  AST_VPW: assert property ($changed(vert_clock_phase1_o) |-> vrun_q >= 16'(VPW0_CYC))
    else $error("vertical pulse too short");
  // The gate pulse before a line must outlast a plain shift by the overlap
  AST_OVERLAP: assert property ($rose(horiz_clock_phase2_o) && vmoved_q |-> tglast_q >= 16'(VPW0_CYC + OVR_CYC))
    else $error("transfer gate overlap too short");
  AST_SHUT_START: assert property (start_i && !busy_o |=> shutter_open_o && busy_o)
    else $error("shutter not opened on start");
  AST_SHUT_REST: assert property (shutter_open_o |-> vert_clock_phase1_o && horiz_clock_phase1_o)
    else $error("clocks moving while shutter open");
  AST_STREAM_HOLD: assert property (pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_data_o) && $stable(pix_line_end_o))
    else $error("stream word changed before taken");

  COV_DONE: cover property ($rose(frame_done_o));
  COV_STALL: cover property (pix_valid_o && !pix_ready_i);
  COV_OVERLAP: cover property ($fell(transfer_gate_o) && horiz_clock_phase1_o);
  COV_LINE_START: cover property ($rose(horiz_clock_phase2_o) && vmoved_q);
endmodule

bind ccd_readout_host ccd_readout_host_chk u_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_i(start_i), .pix_ready_i(pix_ready_i),
  .vert_clock_phase1_o(vert_clock_phase1_o), .vert_clock_phase2_o(vert_clock_phase2_o),
  .transfer_gate_o(transfer_gate_o), .horiz_clock_phase1_o(horiz_clock_phase1_o),
  .horiz_clock_phase2_o(horiz_clock_phase2_o), .summing_gate_o(summing_gate_o),
  .reset_gate_o(reset_gate_o), .shutter_open_o(shutter_open_o), .busy_o(busy_o),
  .frame_done_o(frame_done_o), .pix_valid_o(pix_valid_o), .pix_data_o(pix_data_o),
  .pix_line_end_o(pix_line_end_o)
);
`default_nettype wire

/* File: sim/ccd_readout_host_tb.sv */
// Self-checking bench for the readout sequencer with a sensor model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0d got %0d", n, e, s); end end
module ccd_readout_host_tb import ccd_seq_pkg::*;;
  logic             clk_sys_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic             start_i = 1'b0;
  logic             area_mode_i = 1'b0;
  logic [1:0]       row_sel_i = 2'd0;
  logic             col_sel_i = 1'b0;
  logic [31:0]      integ_cycles_i = 32'd0;
  logic             pix_ready_i = 1'b0;
  logic [ADC_W-1:0] adc_data_i;
  logic [ADC_W-1:0] pix_data_o;
  logic             vp1, vp2, tg, hp1, hp2, sg, rg, shut, busy, done, pvalid, pend, adc_smp;
  int               n_errors, checked, cyc, n_words, pix_bad, vp2_n, hp2_n, rg_n, sh_n, done_n;
  int               widx, smp_n;

  always #10 clk_sys_i = ~clk_sys_i;

  ccd_readout_host uut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_i(start_i), .area_mode_i(area_mode_i),
    .row_sel_i(row_sel_i), .col_sel_i(col_sel_i), .integ_cycles_i(integ_cycles_i),
    .adc_data_i(adc_data_i), .pix_ready_i(pix_ready_i), .vert_clock_phase1_o(vp1),
    .vert_clock_phase2_o(vp2), .transfer_gate_o(tg), .horiz_clock_phase1_o(hp1),
    .horiz_clock_phase2_o(hp2), .summing_gate_o(sg), .reset_gate_o(rg),
    .shutter_open_o(shut), .adc_sample_o(adc_smp), .busy_o(busy), .frame_done_o(done),
    .pix_valid_o(pvalid), .pix_data_o(pix_data_o), .pix_line_end_o(pend));

  ccd_sensor_model u_sensor (.transfer_gate_i(tg), .summing_gate_i(sg), .reset_gate_i(rg),
    .pixel_output_o(adc_data_i));

  // ****************************************
  // Monitors
  // ****************************************
  always @(posedge clk_sys_i) begin
    cyc++;
    if (pvalid === 1'b1 && pix_ready_i) begin
      if (pix_data_o !== widx[15:0] || pend !== (widx == 1043)) pix_bad++;
      widx = (widx == 1043) ? 0 : widx + 1;
      n_words++;
    end
    if (adc_smp === 1'b1) smp_n++;
    if (shut === 1'b1) sh_n++;
    if (done === 1'b1) done_n++;
  end
  always @(posedge vp2) vp2_n++;
  always @(posedge hp2) hp2_n++;
  always @(posedge rg) rg_n++;

  // One long stall in the line overruns the FIFO so the summing gate must stretch
  always @(negedge clk_sys_i) pix_ready_i <= (cyc < 21000) || (cyc >= 26000);

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_rest;
    `CHK("vp1 rest", 1'b1, vp1)
    `CHK("vp2 rest", 1'b0, vp2)
    `CHK("hp1 rest", 1'b1, hp1)
    `CHK("sg rest", 1'b0, sg)
    `CHK("shutter rest", 1'b0, shut)
  endtask

  task automatic t_frame_binning;
    int i;
    integ_cycles_i = 32'd200;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    `CHK("busy", 1'b1, busy)
    `CHK("shutter open", 1'b1, shut)
    repeat (300) @(negedge clk_sys_i);
    `CHK("shutter shut", 1'b0, shut)
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    i = 0;
    while (n_words < 1044 && i < 130000) begin
      @(negedge clk_sys_i);
      i++;
    end
    repeat (300) @(negedge clk_sys_i);
    `CHK("shutter cycles", 200, sh_n)
    `CHK("vertical shifts", 128, vp2_n)
    `CHK("horizontal cycles", 1044, hp2_n)
    `CHK("reset gate pulses", 1044, rg_n)
    `CHK("words", 1044, n_words)
    `CHK("word order", 0, pix_bad)
    `CHK("converter samples", 1044, smp_n)
    `CHK("frames done", 1, done_n)
    `CHK("idle", 1'b0, busy)
  endtask

  task automatic t_area_reset;
    int i, v0, h0, w0;
    v0 = vp2_n;
    h0 = hp2_n;
    w0 = n_words;
    area_mode_i = 1'b1;
    integ_cycles_i = 32'd0;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    `CHK("area shutter", 1'b1, shut)
    i = 0;
    while (hp2_n == h0 && i < 1000) begin
      @(negedge clk_sys_i);
      i++;
    end
    `CHK("area shifts before line", 1, vp2_n - v0)
    `CHK("area shutter shut", 1'b0, shut)
    i = 0;
    while (n_words < w0 + 3 && i < 2000) begin
      @(negedge clk_sys_i);
      i++;
    end
    `CHK("area words", 3, n_words - w0)
    `CHK("area word order", 0, pix_bad)
    `CHK("area rows moved", 1, vp2_n - v0)
    // A reset in mid-frame must drop the frame and park every clock
    rst_n_i = 1'b0;
    @(negedge clk_sys_i);
    t_reset_rest;
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset stream", 1'b0, pvalid)
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    `CHK("idle after reset", 1'b0, busy)
    `CHK("no frame after reset", 1, done_n)
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clk_sys_i);
    t_reset_rest;
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    t_frame_binning;
    t_area_reset;
    tally_and_finish;
  end

  // A binning frame with one stall needs about 126k cycles
  initial begin
    repeat (150000) @(posedge clk_sys_i);
    n_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
